// File: hdl/acsl_top.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
// Contract
// - completion flag sets when result lands
// - result read or status write clears flag
// - software power bit switches converter on/off
// - bit 4 always reads zero
// - three-bit field selects input 0 to 7
// - eight-bit result is read-only
// - converts continuously while powered
// - 64 cycles per conversion, 31.5 sampling (code samples for 32 whole cycles)
// - status write aborts and restarts conversion
// - halt disables until exit plus settling
module acsl_top #(
   parameter int unsigned STAB_CYCLES = acsl_pkg::STAB_CYCLES
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire logic                  comp_in,
   input  wire logic                  halt_mode,
   output acsl_pkg::acsl_analog_s     analog,
   output logic                       irq
);
   localparam int unsigned SW = $clog2(STAB_CYCLES + 1);
   localparam int unsigned RW = acsl_pkg::RES_BITS;
   localparam int unsigned CW = acsl_pkg::CH_W;
   localparam int unsigned EW = acsl_pkg::EV_W;

   generate
      if (STAB_CYCLES < 1) begin : g_chk
         $error("acsl_top: settling count must be at least one cycle");
      end
   endgenerate

   // ************************************************************
   // bus slave
   // ************************************************************
   logic             dp_wr_reg;
   logic [7:0]       dp_idx_reg;
   logic [31:0]      hrdata_reg;
   logic             ap_go, ap_rd;
   logic [7:0]       ap_idx;
   logic [31:0]      rd_mux;
   logic             wr_csr, wr_stat, wr_mask, rd_result;

   assign ap_go     = hsel && hready && htrans[1];
   assign ap_rd     = ap_go && !hwrite;
   assign ap_idx    = haddr[acsl_pkg::IDX_MSB:acsl_pkg::IDX_LSB];
   assign rd_result = ap_rd && (ap_idx == acsl_pkg::RESULT_IDX);
   assign wr_csr    = dp_wr_reg && (dp_idx_reg == acsl_pkg::CSR_IDX);
   assign wr_stat   = dp_wr_reg && (dp_idx_reg == acsl_pkg::EV_STAT_IDX);
   assign wr_mask   = dp_wr_reg && (dp_idx_reg == acsl_pkg::EV_MASK_IDX);
   assign hreadyout = 1'b1;
   assign hresp     = acsl_pkg::HRESP_OKAY;
   assign hrdata    = hrdata_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_reg  <= 1'b0;
         dp_idx_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         dp_wr_reg  <= ap_go && hwrite;
         dp_idx_reg <= ap_idx;
         if (ap_rd) begin
            hrdata_reg <= rd_mux;
         end
      end
   end

   // ************************************************************
   // control and status
   // ************************************************************
   logic             power_reg, coco_reg, coco_next;
   logic [CW-1:0]    chan_reg;
   logic [SW-1:0]    settle_reg;
   logic             ready_reg, ready_next, power_en, run;
   logic [EW-1:0]    ev_stat_reg, ev_mask_reg, ev_set, ev_stat_next;
   logic             comp_s1_reg, comp_s2_reg;
   logic             conv_done, sample;
   logic [RW-1:0]    result, trial;
   logic [7:0]       csr_view;

   // a halted core keeps the power bit but starves the analog side
   assign power_en   = power_reg && !halt_mode;
   assign ready_next = power_en && (ready_reg || settle_reg == SW'(STAB_CYCLES - 1));
   assign run        = power_en && ready_reg;

   // set beats clear so a result landing during a read is still flagged
   assign coco_next = conv_done ? 1'b1
                      : (wr_csr || rd_result) ? 1'b0
                      : coco_reg;

   // reserved bits are not stored, so they always read zero
   assign csr_view = {coco_reg, 1'b0, power_reg, 1'b0, 1'b0, chan_reg};

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (ap_idx == acsl_pkg::RESULT_IDX) begin
         rd_mux[RW-1:0] = result;
      end else if (ap_idx == acsl_pkg::CSR_IDX) begin
         rd_mux[7:0] = csr_view;
      end else if (ap_idx == acsl_pkg::EV_STAT_IDX) begin
         rd_mux[EW-1:0] = ev_stat_reg;
      end else if (ap_idx == acsl_pkg::EV_MASK_IDX) begin
         rd_mux[EW-1:0] = ev_mask_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_reg <= 1'b0;
         chan_reg  <= acsl_pkg::CH_RST;
         coco_reg  <= 1'b0;
      end else begin
         coco_reg <= coco_next;
         if (wr_csr) begin
            power_reg <= hwdata[acsl_pkg::CSR_PWR_BIT];
            chan_reg  <= hwdata[CW-1:0];
         end
      end
   end

   // settling restarts on every power-up and every halt exit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_reg <= '0;
         ready_reg  <= 1'b0;
      end else begin
         ready_reg <= ready_next;
         if (!power_en || ready_reg) begin
            settle_reg <= '0;
         end else begin
            settle_reg <= SW'(settle_reg + 1'b1);
         end
      end
   end

   // ************************************************************
   // comparator and conversion engine
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comp_s1_reg <= 1'b0;
         comp_s2_reg <= 1'b0;
      end else begin
         comp_s1_reg <= comp_in;
         comp_s2_reg <= comp_s1_reg;
      end
   end

   acsl_sar #(
      .RES_W      (RW),
      .CONV_CYC   (acsl_pkg::CONV_CYCLES),
      .SAMPLE_CYC (acsl_pkg::SAMPLE_CYCLES)
   ) u_sar (
      .clk        (hclk),
      .rstn       (hresetn),
      .run        (run),
      .restart    (wr_csr),
      .comp_hi    (comp_s2_reg),
      .sample     (sample),
      .trial      (trial),
      .done       (conv_done),
      .result     (result)
   );

   // one driver for the whole carrier, members are not driven apart
   assign analog = '{power_on: power_en,
                     sample:   sample && run,
                     channel:  chan_reg,
                     trial:    trial};

   // ************************************************************
   // events and interrupt
   // ************************************************************
   always_comb begin
      ev_set                     = '0;
      ev_set[acsl_pkg::EV_DONE]  = conv_done;
      ev_set[acsl_pkg::EV_READY] = ready_next && !ready_reg;
   end

   assign ev_stat_next = (ev_stat_reg & ~(wr_stat ? hwdata[EW-1:0] : EW'(0))) | ev_set;
   assign irq          = |(ev_stat_reg & ev_mask_reg);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_stat_reg <= '0;
         ev_mask_reg <= '0;
      end else begin
         ev_stat_reg <= ev_stat_next;
         if (wr_mask) begin
            ev_mask_reg <= hwdata[EW-1:0];
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_coco_set: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_done |=> coco_reg && result == $past(u_sar.decided, 2))
      else $error("completion flag or result missing after conversion");

   a_coco_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      ((wr_csr || rd_result) && !conv_done) |=> !coco_reg)
      else $error("completion flag not cleared by access");

   a_power_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_csr && !halt_mode) |=> analog.power_on == $past(hwdata[acsl_pkg::CSR_PWR_BIT])
                                 || $changed(halt_mode))
      else $error("power output does not follow the written bit");

   a_bit4_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_rd && ap_idx == acsl_pkg::CSR_IDX) |=> hrdata[4] == 1'b0 && hrdata[6] == 1'b0)
      else $error("reserved status bit reads nonzero");

   a_channel_sel: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_csr |=> analog.channel == $past(hwdata[CW-1:0]))
      else $error("channel select does not follow the write");

   a_result_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !conv_done |-> $stable(result))
      else $error("result changed without a completed conversion");

   a_abort_restart: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_csr && run && hwdata[acsl_pkg::CSR_PWR_BIT] && !halt_mode)
      |=> (analog.sample && !conv_done) [*8])
      else $error("status write did not restart sampling");

   a_halt_off: assert property (@(posedge hclk) disable iff (!hresetn)
      halt_mode |-> !analog.power_on ##1 (!run || !$past(halt_mode) || ready_reg == 1'b0))
      else $error("converter stays on during halt");

   a_settle_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(ready_reg) |-> $past(settle_reg) == SW'(STAB_CYCLES - 1))
      else $error("converter ready before settling elapsed");

   a_continuous: assert property (@(posedge hclk) disable iff (!hresetn)
      (conv_done && run && !wr_csr) |=> sample)
      else $error("next conversion did not follow");

   // ************************************************************
   // checks: fields, result and events
   // ************************************************************
   a_flag_cause: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(coco_reg) |-> $past(conv_done))
      else $error("completion flag set without a conversion");

   a_power_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !wr_csr |=> $stable(power_reg) && $stable(chan_reg))
      else $error("control fields changed without a write");

   a_off_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |=> !sample)
      else $error("engine sampling while switched off");

   a_off_no_done: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |=> !conv_done)
      else $error("conversion completed while switched off");

   a_trial_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |=> trial == '0)
      else $error("trial code not cleared while off");

   a_result_ro: assert property (@(posedge hclk) disable iff (!hresetn)
      (dp_wr_reg && dp_idx_reg == acsl_pkg::RESULT_IDX) |=> $stable(result) || conv_done)
      else $error("bus write changed the result");

   a_result_upper: assert property (@(posedge hclk) disable iff (!hresetn)
      (ap_rd && ap_idx == acsl_pkg::RESULT_IDX) |=> hrdata[31:RW] == '0)
      else $error("result read shows upper bits");

   a_halt_unready: assert property (@(posedge hclk) disable iff (!hresetn)
      halt_mode |=> !ready_reg)
      else $error("converter still ready during halt");

   a_done_event: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_done |=> ev_stat_reg[acsl_pkg::EV_DONE])
      else $error("done event not recorded");

   a_ready_event: assert property (@(posedge hclk) disable iff (!hresetn)
      (ready_next && !ready_reg) |=> ev_stat_reg[acsl_pkg::EV_READY])
      else $error("ready event not recorded");

   a_event_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_stat && hwdata[acsl_pkg::EV_DONE] && !conv_done)
      |=> !ev_stat_reg[acsl_pkg::EV_DONE])
      else $error("done event not cleared by write");

endmodule

// File: inc/acsl_pkg.sv
package acsl_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_PS  = 5000;
   localparam int unsigned STAB_TIME_US   = 30;
   localparam int unsigned STAB_CYCLES    =
      (STAB_TIME_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CONV_CYCLES    = 64;
   // sampling lasts 31.5 cycles, held as half cycles, rounded up
   localparam int unsigned SAMPLE_HALVES  = 63;
   localparam int unsigned SAMPLE_CYCLES  = (SAMPLE_HALVES + 1) / 2;
   localparam int unsigned RES_BITS       = 8;

   // ************************************************************
   // register map: printed index, byte address is four times it
   // ************************************************************
   localparam logic [7:0] RESULT_IDX      = 8'h70;
   localparam logic [7:0] CSR_IDX         = 8'h71;
   localparam logic [7:0] EV_STAT_IDX     = 8'h72;
   localparam logic [7:0] EV_MASK_IDX     = 8'h73;
   localparam int unsigned IDX_LSB        = 2;
   localparam int unsigned IDX_MSB        = 9;

   localparam int unsigned CSR_COCO_BIT   = 7;
   localparam int unsigned CSR_PWR_BIT    = 5;
   localparam int unsigned CH_W           = 3;
   localparam logic [7:0]  RESULT_RST     = 8'h00;
   localparam logic [CH_W-1:0] CH_RST     = 3'h0;

   localparam int unsigned EV_DONE        = 0;
   localparam int unsigned EV_READY       = 1;
   localparam int unsigned EV_W           = 2;

   localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
   localparam logic       HRESP_OKAY      = 1'h0;

   typedef enum logic [1:0] {
      ACSL_IDLE   = 2'h0,
      ACSL_SAMPLE = 2'h1,
      ACSL_DECIDE = 2'h3
   } acsl_sar_state_e;

   typedef struct packed {
      logic                power_on;
      logic                sample;
      logic [CH_W-1:0]     channel;
      logic [RES_BITS-1:0] trial;
   } acsl_analog_s;

endpackage

// File: hdl/acsl_sar.sv
`timescale 1ns/100ps
module acsl_sar #(
   parameter int unsigned RES_W      = acsl_pkg::RES_BITS,
   parameter int unsigned CONV_CYC   = acsl_pkg::CONV_CYCLES,
   parameter int unsigned SAMPLE_CYC = acsl_pkg::SAMPLE_CYCLES
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             run,
   input  wire logic             restart,
   input  wire logic             comp_hi,
   output logic                  sample,
   output logic [RES_W-1:0]      trial,
   output logic                  done,
   output logic [RES_W-1:0]      result
);
   localparam int unsigned BIT_CYC = (CONV_CYC - SAMPLE_CYC) / RES_W;
   localparam int unsigned CNT_W   = $clog2(CONV_CYC);

   // comparator arrives through a two-stage synchroniser
   generate
      if (BIT_CYC < 3 || BIT_CYC * RES_W + SAMPLE_CYC != CONV_CYC) begin : g_chk
         $error("acsl_sar: bit slots do not fit the conversion time");
      end
   endgenerate

   acsl_pkg::acsl_sar_state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next, bit_cnt;
   logic [RES_W-1:0] sar_reg, sar_next, onehot, decided;
   logic [RES_W-1:0] result_reg, result_next;
   logic             done_reg, slot_end, last;
   logic [CNT_W-1:0] age_reg;

   assign bit_cnt  = CNT_W'(cnt_reg - CNT_W'(SAMPLE_CYC));
   assign onehot   = RES_W'(1) << (RES_W - 1 - (bit_cnt / CNT_W'(BIT_CYC)));
   assign slot_end = (state_reg == acsl_pkg::ACSL_DECIDE)
                     && (bit_cnt % CNT_W'(BIT_CYC) == CNT_W'(BIT_CYC - 1));
   assign last     = slot_end && (cnt_reg == CNT_W'(CONV_CYC - 1));
   assign decided  = comp_hi ? sar_reg : (sar_reg & ~onehot);

   always_comb begin
      state_next  = state_reg;
      cnt_next    = CNT_W'(cnt_reg + 1'b1);
      sar_next    = sar_reg;
      result_next = result_reg;
      if (!run) begin
         state_next = acsl_pkg::ACSL_IDLE;
         cnt_next   = '0;
         sar_next   = '0;
      end else if (restart || state_reg == acsl_pkg::ACSL_IDLE || last) begin
         state_next = acsl_pkg::ACSL_SAMPLE;
         cnt_next   = '0;
         sar_next   = '0;
         if (last && !restart) begin
            result_next = decided;
         end
      end else if (state_reg == acsl_pkg::ACSL_SAMPLE) begin
         if (cnt_reg == CNT_W'(SAMPLE_CYC - 1)) begin
            state_next = acsl_pkg::ACSL_DECIDE;
            sar_next   = RES_W'(1) << (RES_W - 1);
         end
      end else if (slot_end) begin
         sar_next = decided | (onehot >> 1);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg  <= acsl_pkg::ACSL_IDLE;
         cnt_reg    <= '0;
         sar_reg    <= '0;
         result_reg <= '0;
         done_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         sar_reg    <= sar_next;
         result_reg <= result_next;
         done_reg   <= run && last && !restart;
      end
   end

   assign sample = (state_reg == acsl_pkg::ACSL_SAMPLE);
   assign trial  = sar_reg;
   assign done   = done_reg;
   assign result = result_reg;

   // ************************************************************
   // checks
   // ************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         age_reg <= '0;
      end else if (!sample || state_next != state_reg || cnt_next == '0) begin
         age_reg <= (state_next == acsl_pkg::ACSL_SAMPLE && cnt_next == '0) ? '0
                    : CNT_W'(age_reg + 1'b1);
      end else begin
         age_reg <= CNT_W'(age_reg + 1'b1);
      end
   end

   a_conv_length: assert property (@(posedge clk) disable iff (!rstn)
      (run && last && !restart) |-> age_reg == CNT_W'(CONV_CYC - 1))
      else $error("conversion did not take the full cycle count");

   a_sample_length: assert property (@(posedge clk) disable iff (!rstn)
      (run && !restart && sample && state_next == acsl_pkg::ACSL_DECIDE)
      |-> age_reg == CNT_W'(SAMPLE_CYC - 1))
      else $error("sampling phase has the wrong length");

   a_msb_first: assert property (@(posedge clk) disable iff (!rstn)
      (run && !restart && sample && state_next == acsl_pkg::ACSL_DECIDE)
      |=> trial == RES_W'(1) << (RES_W - 1))
      else $error("approximation does not start at the top bit");

endmodule

// File: dv/tb.sv
`timescale 1ns/100ps
module tb;
   // ************************************************************
   // signals
   // ************************************************************
   localparam int unsigned STAB = 20;
   logic                   hclk;
   logic                   hresetn;
   logic                   hsel;
   logic [31:0]            haddr;
   logic [1:0]             htrans;
   logic                   hwrite;
   logic [2:0]             hsize;
   logic [31:0]            hwdata;
   wire logic              hready;
   logic                   hreadyout;
   logic                   hresp;
   logic [31:0]            hrdata;
   logic                   comp_in;
   logic                   halt_mode;
   acsl_pkg::acsl_analog_s analog;
   logic                   irq;
   logic [7:0]             target;
   logic [31:0]            rd;
   int                     errors;
   int                     checks;

   // one slave, so its ready is the bus ready
   assign hready = hreadyout;

   acsl_top #(.STAB_CYCLES(STAB)) dut (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .comp_in   (comp_in),
      .halt_mode (halt_mode),
      .analog    (analog),
      .irq       (irq)
   );

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // ideal comparator: input level is target
   always @(posedge hclk) begin
      comp_in <= (target >= analog.trial);
   end

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= acsl_pkg::HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      // no cycle limit: only the watchdog ends a stalled transfer
      do begin
         @(posedge hclk);
      end while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
      end while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0);
      chk(nm, e, rd);
   endtask

   task automatic poll_flag();
      int n;
      n = 0;
      do begin
         bus(1'b0, acsl_pkg::CSR_IDX, 32'h0);
         n++;
      end while (rd[7] !== 1'b1 && n < 60);
      chk("completion flag", 32'h1, {31'h0, rd[7]});
   endtask

   task automatic wait_smp(input logic v, input int lim);
      int n;
      n = 0;
      @(negedge hclk);
      while (analog.sample !== v && n < lim) begin
         @(negedge hclk);
         n++;
      end
      chk("sample wait", {31'h0, v}, {31'h0, analog.sample});
   endtask

   task automatic count_hi(input int n, output int hi);
      hi = 0;
      repeat (n) begin
         @(negedge hclk);
         if (analog.sample === 1'b1) hi++;
      end
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      @(negedge hclk);
      chk("analog at reset", 32'h0, 32'(analog));
      chk("irq at reset", 32'h0, {31'h0, irq});
      chk("hresp okay", 32'h0, {31'h0, hresp});
      chk("hreadyout high", 32'h1, {31'h0, hreadyout});
      rdchk("result reset", acsl_pkg::RESULT_IDX, 32'h0);
      rdchk("csr reset", acsl_pkg::CSR_IDX, 32'h0);
      rdchk("stat reset", acsl_pkg::EV_STAT_IDX, 32'h0);
      rdchk("mask reset", acsl_pkg::EV_MASK_IDX, 32'h0);
   endtask

   task automatic t_fields();
      for (int ch = 0; ch < 8; ch++) begin
         wr(acsl_pkg::CSR_IDX, 32'h10 | 32'(ch));
         rdchk("csr channel", acsl_pkg::CSR_IDX, 32'(ch));
         chk("analog channel", 32'(ch), 32'(analog.channel));
         chk("power while off", 32'h0, {31'h0, analog.power_on});
      end
      // result is read-only; unmapped place reads zero
      wr(acsl_pkg::RESULT_IDX, 32'hFF);
      rdchk("result read-only", acsl_pkg::RESULT_IDX, 32'h0);
      wr(8'h7F, 32'h5A);
      rdchk("unmapped", 8'h7F, 32'h0);
   endtask

   task automatic t_convert();
      int hi;
      int k;
      target = 8'hA5;
      wr(acsl_pkg::CSR_IDX, 32'h23);
      @(negedge hclk);
      chk("power on", 32'h1, {31'h0, analog.power_on});
      chk("channel 3", 32'h3, 32'(analog.channel));
      wait_smp(1'b1, STAB + 20);
      hi = 1;
      k = 0;
      @(negedge hclk);
      while (analog.sample === 1'b1 && hi < 100) begin
         hi++;
         @(negedge hclk);
      end
      chk("sampling length", 32'd32, 32'(hi));
      while (analog.sample === 1'b0 && k < 100) begin
         if (k == 1) chk("trial slot 0", 32'h80, 32'(analog.trial));
         if (k == 5) chk("trial slot 1", 32'hC0, 32'(analog.trial));
         if (k == 9) chk("trial slot 2", 32'hA0, 32'(analog.trial));
         k++;
         @(negedge hclk);
      end
      chk("conversion period", 32'd64, 32'(hi + k));
      poll_flag();
      rdchk("result value", acsl_pkg::RESULT_IDX, 32'hA5);
      rdchk("flag cleared by read", acsl_pkg::CSR_IDX, 32'h23);
   endtask

   task automatic t_restart();
      logic [7:0] vals [3];
      vals = '{8'h3C, 8'h00, 8'hFF};
      poll_flag();
      wait_smp(1'b0, 80);
      repeat (8) @(posedge hclk);
      // mid-decide write must abort and resample
      wr(acsl_pkg::CSR_IDX, 32'h23);
      @(negedge hclk);
      chk("restart sampling", 32'h1, {31'h0, analog.sample});
      rdchk("flag cleared by write", acsl_pkg::CSR_IDX, 32'h23);
      foreach (vals[i]) begin
         target = vals[i];
         wr(acsl_pkg::CSR_IDX, 32'h23);
         poll_flag();
         rdchk("result boundary", acsl_pkg::RESULT_IDX, 32'(vals[i]));
      end
   endtask

   task automatic t_irq();
      int n;
      rdchk("events seen", acsl_pkg::EV_STAT_IDX, 32'h3);
      wr(acsl_pkg::EV_MASK_IDX, 32'h2);
      @(negedge hclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(acsl_pkg::EV_STAT_IDX, 32'h2);
      @(negedge hclk);
      chk("irq after clear", 32'h0, {31'h0, irq});
      bus(1'b0, acsl_pkg::EV_STAT_IDX, 32'h0);
      chk("ready cleared", 32'h0, {31'h0, rd[1]});
      wr(acsl_pkg::EV_STAT_IDX, 32'h1);
      wr(acsl_pkg::EV_MASK_IDX, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 80) begin
         @(negedge hclk);
         n++;
      end
      chk("irq on done", 32'h1, {31'h0, irq});
      wr(acsl_pkg::EV_MASK_IDX, 32'h0);
      @(negedge hclk);
      chk("irq masked", 32'h0, {31'h0, irq});
   endtask

   task automatic t_halt();
      int hi;
      @(posedge hclk);
      halt_mode <= 1'b1;
      @(negedge hclk);
      chk("power in halt", 32'h0, {31'h0, analog.power_on});
      count_hi(80, hi);
      chk("no sampling in halt", 32'h0, 32'(hi));
      @(posedge hclk);
      halt_mode <= 1'b0;
      count_hi(STAB - 2, hi);
      chk("settling after halt", 32'h0, 32'(hi));
      wait_smp(1'b1, 40);
   endtask

   task automatic t_off();
      wr(acsl_pkg::CSR_IDX, 32'h0);
      @(negedge hclk);
      chk("power off", 32'h0, {31'h0, analog.power_on});
      bus(1'b0, acsl_pkg::RESULT_IDX, 32'h0);
      repeat (150) @(posedge hclk);
      rdchk("no flag when off", acsl_pkg::CSR_IDX, 32'h0);
   endtask

   // ************************************************************
   // run control
   // ************************************************************
   task automatic test_done();
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      halt_mode = 1'b0;
      comp_in = 1'b0;
      target = 8'h00;
      errors = 0;
      checks = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_fields();
      t_convert();
      t_restart();
      t_irq();
      t_halt();
      t_off();
      test_done();
   end

   // whole run is under two thousand cycles
   initial begin
      #200000;
      errors++;
      test_done();
   end
endmodule
